// >>> src/ioh_err_decode_ctrl.sv
// Error reporting and inbound decode control registers for the hub.
// Assumes an Avalon-MM master on CLK_SYS and event pulses from port
// logic on the same clock; strap pins are asynchronous.
//
// The Avalon-MM slave port is implemented here, with one wait cycle per access.
`timescale 1ns/10ps
`default_nettype none
`include "ioh_regs.svh"

module ioh_err_decode_ctrl
	import ioh_pkg::*;
#(
	parameter int         ADDR_W      = 10,
	parameter int         NP_CNT_W    = 8,
	parameter int         LEN_W       = 12,
	parameter bit         EXPRESS_PORT = 1'b1
) (
	input  wire logic              CLK_SYS,
	input  wire logic              SYS_RST,
	input  wire logic [ADDR_W-1:0] AVS_ADDRESS,
	input  wire logic              AVS_READ,
	input  wire logic              AVS_WRITE,
	input  wire logic [3:0]        AVS_BYTEENABLE,
	input  wire logic [31:0]       AVS_WRITEDATA,
	output logic      [31:0]       AVS_READDATA,
	output logic                   AVS_WAITREQUEST,
	input  wire ioh_err_ev_t       ERR_EV,
	output ioh_err_rep_t           ERR_REP,
	input  wire logic              NP_ISSUE,
	input  wire logic              NP_CPL,
	input  wire logic              RX_TLP_VALID,
	input  wire logic [LEN_W-1:0]  RX_TLP_BYTES,
	output logic                   RX_OVERSIZE,
	input  wire logic              TX_REQ_VALID,
	input  wire logic [LEN_W-1:0]  TX_REQ_BYTES,
	output logic                   TX_REQ_ALLOW,
	output logic      [LEN_W-1:0]  MAX_PAYLOAD_BYTES,
	output logic                   TAG_8BIT_EN,
	output logic                   RELAXED_ORDER_ORIG,
	input  wire logic              IB_VALID,
	input  wire logic [63:0]       IB_ADDR,
	input  wire logic              IB_IN_CSR_RANGE,
	output logic                   IB_ABORT,
	output logic                   IB_PRIV_CSR,
	output ioh_decode_t            DECODE,
	input  wire logic [2:0]        STRAP_PINS
);

	// ************************************************************
	// Parameter checks
	// ************************************************************
	// The word index needs address bits 9:2 and lengths must hold 256
	if (ADDR_W < 10) begin : g_chk_addr
		$error("ioh_err_decode_ctrl: ADDR_W below 10");
	end
	if (NP_CNT_W < 1) begin : g_chk_cnt
		$error("ioh_err_decode_ctrl: NP_CNT_W below 1");
	end
	if (LEN_W < 12) begin : g_chk_len
		$error("ioh_err_decode_ctrl: LEN_W below 12");
	end

	// ************************************************************
	// Bus slave
	// ************************************************************
	logic              wait_r;
	logic [31:0]       rdata_r;
	logic [7:0]        idx;
	logic              wr_go;
	logic [31:0]       bmask;
	logic [15:0]       express_device_control_r;
	logic [15:0]       express_device_status;
	logic [31:0]       misc_r;
	logic [31:0]       strap_sts;
	logic              ur_det_r;
	logic              fatal_det_r;
	logic              nonfatal_det_r;
	logic              corr_det_r;
	logic [NP_CNT_W-1:0] np_cnt_r;

	assign idx   = AVS_ADDRESS[9:2];
	// Write lands only at the edge where the master sees waitrequest low
	assign wr_go = AVS_WRITE && !wait_r;

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_be
			assign bmask[g*8 +: 8] = {8{AVS_BYTEENABLE[g]}};
		end
	endgenerate

	// One wait cycle per access, then a single cycle of acceptance
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST)
			wait_r <= 1'b1;
		else if ((AVS_READ || AVS_WRITE) && wait_r)
			wait_r <= 1'b0;
		else
			wait_r <= 1'b1;
	end

	// Read data is latched at the arming edge so it stands in the answer cycle
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			rdata_r <= 32'h0000_0000;
		end else if (AVS_READ && wait_r) begin
			unique case (idx)
				`IOH_IDX_EXPRESS_DEVICE_CONTROL:  rdata_r <= {16'h0000, express_device_control_r};
				`IOH_IDX_EXPRESS_DEVICE_STATUS:   rdata_r <= {16'h0000, express_device_status};
				`IOH_IDX_MISCCTRL: rdata_r <= misc_r;
				`IOH_IDX_STRAPSTS: rdata_r <= strap_sts;
				default:           rdata_r <= 32'h0000_0000;
			endcase
		end
	end

	assign AVS_WAITREQUEST = wait_r;
	assign AVS_READDATA    = rdata_r;

	// ************************************************************
	// Device control
	// ************************************************************
	logic [15:0] dc_wmask;

	// Bits 15:9 stay zero; the mask keeps writes off them
	assign dc_wmask = bmask[15:0] & `IOH_DC_WMASK;

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST)
			express_device_control_r <= 16'h0000;
		else if (wr_go && idx == `IOH_IDX_EXPRESS_DEVICE_CONTROL)
			express_device_control_r <= (express_device_control_r & ~dc_wmask) | (AVS_WRITEDATA[15:0] & dc_wmask);
	end

	logic [2:0]       mps_code;
	logic [LEN_W-1:0] mps_bytes;

	assign mps_code = express_device_control_r[`IOH_DC_MPS_HI:`IOH_DC_MPS_LO];

	always_comb begin
		// Unlisted codes and non-express ports alias to the smallest payload
		mps_bytes = LEN_W'(`IOH_BYTES_128);
		if (mps_code == `IOH_MPS_256 && EXPRESS_PORT)
			mps_bytes = LEN_W'(`IOH_BYTES_256);
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			MAX_PAYLOAD_BYTES  <= LEN_W'(`IOH_BYTES_128);
			TAG_8BIT_EN        <= 1'b0;
			RELAXED_ORDER_ORIG <= 1'b0;
		end else begin
			MAX_PAYLOAD_BYTES  <= mps_bytes;
			TAG_8BIT_EN        <= express_device_control_r[`IOH_DC_XTAG];
			// The enable bit is stored but never sets the attribute
			RELAXED_ORDER_ORIG <= 1'b0;
		end
	end

	// ************************************************************
	// Payload checks
	// ************************************************************
	// Checks use the advertised limit, so they never disagree with it
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			RX_OVERSIZE  <= 1'b0;
			TX_REQ_ALLOW <= 1'b0;
		end else begin
			RX_OVERSIZE  <= RX_TLP_VALID && (RX_TLP_BYTES > MAX_PAYLOAD_BYTES);
			TX_REQ_ALLOW <= TX_REQ_VALID && (TX_REQ_BYTES <= MAX_PAYLOAD_BYTES);
		end
	end

	// ************************************************************
	// Error reporting
	// ************************************************************
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			ERR_REP <= '0;
		end else begin
			ERR_REP.ur           <= ERR_EV.ur && express_device_control_r[`IOH_DC_UR];
			ERR_REP.fatal        <= ERR_EV.fatal && express_device_control_r[`IOH_DC_FATAL];
			ERR_REP.nonfatal     <= (ERR_EV.nonfatal || ERR_EV.perfmon_nf)
			                        && express_device_control_r[`IOH_DC_NONFATAL];
			ERR_REP.corr         <= ERR_EV.corr && express_device_control_r[`IOH_DC_CORR];
			// Internal errors bypass the link enables entirely
			ERR_REP.int_fatal    <= ERR_EV.int_fatal;
			ERR_REP.int_nonfatal <= ERR_EV.int_nonfatal;
			ERR_REP.int_corr     <= ERR_EV.int_corr;
		end
	end

	// ************************************************************
	// Device status
	// ************************************************************
	logic sts_wr;
	logic [3:0] sts_clr;

	// Write one to clear; a same-cycle event wins over the clear
	assign sts_wr  = wr_go && idx == `IOH_IDX_EXPRESS_DEVICE_STATUS && AVS_BYTEENABLE[0];
	assign sts_clr = sts_wr ? AVS_WRITEDATA[3:0] : 4'h0;

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST)
			ur_det_r <= 1'b0;
		else if (ERR_EV.ur)
			ur_det_r <= 1'b1;
		else if (sts_clr[`IOH_DS_UR])
			ur_det_r <= 1'b0;
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST)
			fatal_det_r <= 1'b0;
		else if (ERR_EV.fatal || ERR_EV.int_fatal)
			fatal_det_r <= 1'b1;
		else if (sts_clr[`IOH_DS_FATAL])
			fatal_det_r <= 1'b0;
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST)
			nonfatal_det_r <= 1'b0;
		else if (ERR_EV.nonfatal || ERR_EV.perfmon_nf || ERR_EV.int_nonfatal)
			nonfatal_det_r <= 1'b1;
		else if (sts_clr[`IOH_DS_NONFATAL])
			nonfatal_det_r <= 1'b0;
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST)
			corr_det_r <= 1'b0;
		else if (ERR_EV.corr || ERR_EV.int_corr)
			corr_det_r <= 1'b1;
		else if (sts_clr[`IOH_DS_CORR])
			corr_det_r <= 1'b0;
	end

	// Outstanding non-posted count; saturates rather than wraps
	logic [NP_CNT_W-1:0] np_cnt_nxt;

	always_comb begin
		np_cnt_nxt = np_cnt_r;
		if (NP_ISSUE && !NP_CPL && np_cnt_r != {NP_CNT_W{1'b1}})
			np_cnt_nxt = np_cnt_r + 1'b1;
		else if (NP_CPL && !NP_ISSUE && np_cnt_r != '0)
			np_cnt_nxt = np_cnt_r - 1'b1;
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST)
			np_cnt_r <= '0;
		else
			np_cnt_r <= np_cnt_nxt;
	end

	always_comb begin
		express_device_status                    = 16'h0000;
		express_device_status[`IOH_DS_CORR]      = corr_det_r;
		express_device_status[`IOH_DS_NONFATAL]  = nonfatal_det_r;
		express_device_status[`IOH_DS_FATAL]     = fatal_det_r;
		express_device_status[`IOH_DS_UR]        = ur_det_r;
		express_device_status[`IOH_DS_TPEND]     = np_cnt_r != '0;
	end

	// ************************************************************
	// Misc control and inbound decode
	// ************************************************************
	logic [31:0] mc_wmask;

	assign mc_wmask = bmask & `IOH_MC_WMASK;

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST)
			misc_r <= `IOH_MC_RESET;
		else if (wr_go && idx == `IOH_IDX_MISCCTRL)
			misc_r <= (misc_r & ~mc_wmask) | (AVS_WRITEDATA & mc_wmask);
	end

	logic [1:0] subdec;
	logic [4:0] toa;
	logic [6:0] limit_exp;
	logic       above_4g;
	logic       crosses;

	assign subdec    = misc_r[`IOH_MC_SUBDEC_HI:`IOH_MC_SUBDEC_LO];
	assign toa       = misc_r[`IOH_MC_TOA_HI:`IOH_MC_TOA_LO];
	assign limit_exp = `IOH_TOA_BASE + {2'b00, toa};
	assign above_4g  = IB_ADDR[63:32] != 32'h0000_0000;
	// Anything at or above 2^(32+field) lies beyond the limit
	assign crosses   = limit_exp < 7'd64 && (IB_ADDR >> limit_exp[5:0]) != 64'h0;

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			IB_ABORT <= 1'b0;
		end else begin
			IB_ABORT <= IB_VALID && (crosses
			            || (IB_IN_CSR_RANGE && misc_r[`IOH_MC_CSR_ABORT]));
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			IB_PRIV_CSR <= 1'b0;
		end else begin
			IB_PRIV_CSR <= IB_VALID && misc_r[`IOH_MC_TOA_VALID]
			               && above_4g && !crosses;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			DECODE <= '0;
			DECODE.bridge_ranges_ignore  <= 1'b1;
			DECODE.top_of_addressability <= 5'(`IOH_MC_RESET >> `IOH_MC_TOA_LO);
		end else begin
			DECODE.csr_ib_abort          <= misc_r[`IOH_MC_CSR_ABORT];
			DECODE.lock_thaw_np          <= misc_r[`IOH_MC_LOCK_THAW];
			// Reserved codes steer nowhere new; only 11 selects the interconnect
			DECODE.subdec_proc           <= subdec == `IOH_SUBDEC_PROC;
			DECODE.bridge_ranges_ignore  <= subdec == `IOH_SUBDEC_LINK;
			DECODE.io_fine_granularity   <= misc_r[`IOH_MC_FINE_IO];
			DECODE.addressability_valid  <= misc_r[`IOH_MC_TOA_VALID];
			DECODE.top_of_addressability <= toa;
		end
	end

	// ************************************************************
	// Strap status
	// ************************************************************
	logic [`IOH_STRAP_W-1:0] strap_meta_r;
	logic [`IOH_STRAP_W-1:0] strap_sync_r;

	// Pins are asynchronous; second stage is the only reader of the first
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			strap_meta_r <= '1;
			strap_sync_r <= '1;
		end else begin
			strap_meta_r <= STRAP_PINS;
			strap_sync_r <= strap_meta_r;
		end
	end

	// Bits 4 and 3 always read one; the rest of the upper field is reserved
	assign strap_sts = `IOH_SS_FIXED | {29'h0, strap_sync_r};

endmodule

`default_nettype wire

// >>> src/ioh_pkg.sv
// Types shared by the hub error and decode control block.
// Assumes the constants header is included by the design file.
`default_nettype none
package ioh_pkg;

	// Error events, one-cycle pulses from the port logic
	typedef struct packed {
		logic ur;
		logic ur_fwd_cpl;
		logic fatal;
		logic nonfatal;
		logic corr;
		logic perfmon_nf;
		logic int_fatal;
		logic int_nonfatal;
		logic int_corr;
	} ioh_err_ev_t;

	// Error reports toward the message logic
	typedef struct packed {
		logic ur;
		logic fatal;
		logic nonfatal;
		logic corr;
		logic int_fatal;
		logic int_nonfatal;
		logic int_corr;
	} ioh_err_rep_t;

	// Decode steering derived from the misc control register
	typedef struct packed {
		logic       csr_ib_abort;
		logic       lock_thaw_np;
		logic       subdec_proc;
		logic       bridge_ranges_ignore;
		logic       io_fine_granularity;
		logic       addressability_valid;
		logic [4:0] top_of_addressability;
	} ioh_decode_t;

endpackage

`default_nettype wire

// >>> src/ioh_regs.svh
// Register indices, field positions, reset values and decode constants
// for the hub error and decode control block.
// Assumes a 32-bit register bus addressed by byte, one word per index.
`ifndef IOH_REGS_SVH
`define IOH_REGS_SVH

// Register indices; the byte address is four times the index
`define IOH_IDX_EXPRESS_DEVICE_CONTROL     8'h48
`define IOH_IDX_EXPRESS_DEVICE_STATUS      8'h4A
`define IOH_IDX_MISCCTRL    8'h50
`define IOH_IDX_STRAPSTS    8'h51

// Device control fields
`define IOH_DC_CORR         0
`define IOH_DC_NONFATAL     1
`define IOH_DC_FATAL        2
`define IOH_DC_UR           3
`define IOH_DC_RELAX        4
`define IOH_DC_MPS_LO       5
`define IOH_DC_MPS_HI       7
`define IOH_DC_XTAG         8
`define IOH_DC_WMASK        16'h01FF

// Device status fields
`define IOH_DS_CORR         0
`define IOH_DS_NONFATAL     1
`define IOH_DS_FATAL        2
`define IOH_DS_UR           3
`define IOH_DS_TPEND        5

// Misc control fields
`define IOH_MC_FINE_IO      2
`define IOH_MC_TOA_LO       3
`define IOH_MC_TOA_HI       7
`define IOH_MC_TOA_VALID    8
`define IOH_MC_SUBDEC_LO    10
`define IOH_MC_SUBDEC_HI    11
`define IOH_MC_LOCK_THAW    12
`define IOH_MC_CSR_ABORT    13
`define IOH_MC_RESET        32'h0000_0020
`define IOH_MC_WMASK        32'h0000_3D04

// Strap status: bits 4 and 3 read one, bits 2:0 hold the strap
`define IOH_SS_FIXED        32'h0000_0018
`define IOH_STRAP_W         3

// Payload encodings and sizes in bytes
`define IOH_MPS_128         3'h0
`define IOH_MPS_256         3'h1
`define IOH_BYTES_128       12'h080
`define IOH_BYTES_256       12'h100

// Subtractive decode port codes
`define IOH_SUBDEC_LINK     2'h0
`define IOH_SUBDEC_PROC     2'h3

// Addressability limit base exponent
`define IOH_TOA_BASE        7'h20

`endif

// >>> testbench/ioh_err_decode_ctrl_props.sv
// Checker bound to the hub error and decode control block.
// Sees only top-level ports; one clock domain.
`timescale 1ns/10ps
`default_nettype none
module ioh_chk
	import ioh_pkg::*;
#(
	parameter int LEN_W = 12
) (
	input wire logic             CLK_SYS,
	input wire logic             SYS_RST,
	input wire ioh_err_ev_t      ERR_EV,
	input wire ioh_err_rep_t     ERR_REP,
	input wire logic             RX_TLP_VALID,
	input wire logic [LEN_W-1:0] RX_TLP_BYTES,
	input wire logic             RX_OVERSIZE,
	input wire logic             TX_REQ_VALID,
	input wire logic [LEN_W-1:0] TX_REQ_BYTES,
	input wire logic             TX_REQ_ALLOW,
	input wire logic [LEN_W-1:0] MAX_PAYLOAD_BYTES,
	input wire logic             RELAXED_ORDER_ORIG,
	input wire logic             IB_VALID,
	input wire logic [63:0]      IB_ADDR,
	input wire logic             IB_IN_CSR_RANGE,
	input wire logic             IB_ABORT,
	input wire logic             IB_PRIV_CSR,
	input wire ioh_decode_t      DECODE
);
	logic [63:0] lim;
	// Limit field is read-only, so its registered copy never lags
	assign lim = 64'h1 << (6'h20 + 6'(DECODE.top_of_addressability));
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (SYS_RST);
	property p_relax; RELAXED_ORDER_ORIG == 1'h0; endproperty
	a_relax: assert property (p_relax) else $error("relaxed ordering set");
	property p_fwd; ERR_EV.ur_fwd_cpl && !ERR_EV.ur |=> !ERR_REP.ur; endproperty
	a_fwd: assert property (p_fwd) else $error("forwarded completion reported");
	property p_int; ERR_REP[2:0] == $past(ERR_EV[2:0]); endproperty
	a_int: assert property (p_int) else $error("internal report wrong");
	property p_rx; RX_TLP_VALID && RX_TLP_BYTES > MAX_PAYLOAD_BYTES |=> RX_OVERSIZE; endproperty
	a_rx: assert property (p_rx) else $error("oversize missed");
	property p_tx; TX_REQ_VALID && TX_REQ_BYTES > MAX_PAYLOAD_BYTES |=> !TX_REQ_ALLOW; endproperty
	a_tx: assert property (p_tx) else $error("oversize request allowed");
	property p_csr; IB_VALID && IB_IN_CSR_RANGE && DECODE.csr_ib_abort |=> IB_ABORT; endproperty
	a_csr: assert property (p_csr) else $error("csr access not aborted");
	property p_lim; IB_VALID && IB_ADDR >= lim |=> IB_ABORT && !IB_PRIV_CSR; endproperty
	a_lim: assert property (p_lim) else $error("limit crossing not aborted");
	property p_priv; IB_VALID && DECODE.addressability_valid && IB_ADDR >= 64'h1_0000_0000
		&& IB_ADDR < lim |=> IB_PRIV_CSR; endproperty
	a_priv: assert property (p_priv) else $error("privileged decode missed");
endmodule
bind ioh_err_decode_ctrl ioh_chk #(.LEN_W(LEN_W)) u_chk (
	.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .ERR_EV(ERR_EV), .ERR_REP(ERR_REP),
	.RX_TLP_VALID(RX_TLP_VALID), .RX_TLP_BYTES(RX_TLP_BYTES), .RX_OVERSIZE(RX_OVERSIZE),
	.TX_REQ_VALID(TX_REQ_VALID), .TX_REQ_BYTES(TX_REQ_BYTES), .TX_REQ_ALLOW(TX_REQ_ALLOW),
	.MAX_PAYLOAD_BYTES(MAX_PAYLOAD_BYTES), .RELAXED_ORDER_ORIG(RELAXED_ORDER_ORIG), .IB_VALID(IB_VALID),
	.IB_ADDR(IB_ADDR), .IB_IN_CSR_RANGE(IB_IN_CSR_RANGE), .IB_ABORT(IB_ABORT), .IB_PRIV_CSR(IB_PRIV_CSR),
	.DECODE(DECODE)
);
`default_nettype wire

// >>> testbench/ioh_err_decode_ctrl_tb.sv
// Bench for the hub error and decode control block: bus tasks and checks.
// Assumes the link model drives the far side and the checker is bound in.
`timescale 1ns/10ps
`default_nettype none
`include "ioh_regs.svh"
module ioh_err_decode_ctrl_tb
	import ioh_pkg::*;
;
	localparam logic [7:0] ctl = `IOH_IDX_EXPRESS_DEVICE_CONTROL;
	localparam logic [7:0] sts = `IOH_IDX_EXPRESS_DEVICE_STATUS;
	localparam logic [7:0] msc = `IOH_IDX_MISCCTRL;
	localparam logic [7:0] stp = `IOH_IDX_STRAPSTS;
	logic         clk_sys = 1'h0;
	logic         sys_rst = 1'h1;
	logic         rd = 1'h0;
	logic         wr = 1'h0;
	logic         rxv = 1'h0;
	logic         txv = 1'h0;
	logic [9:0]   addr = '0;
	logic [11:0]  rxb = '0;
	logic [11:0]  txb = '0;
	logic [31:0]  wdata = '0;
	logic [31:0]  rdata, r;
	logic [11:0]  mps;
	logic [63:0]  iba;
	logic [2:0]   strap;
	logic         waitreq, np_i, np_c, ibv, ibc, rxo, txa, tag8, ro, ib_ab, ib_pr;
	ioh_err_ev_t  ev;
	ioh_err_rep_t rep;
	ioh_decode_t  dec;
	int           err_count = 0;
	int           checked = 0;
	int           cyc = 0;
	int           evb[4] = '{4, 5, 6, 8};
	always #2.5 clk_sys = ~clk_sys;
	ioh_link_model lm (.clk(clk_sys), .ev(ev), .np_i(np_i), .np_c(np_c), .ibv(ibv), .iba(iba), .ibc(ibc),
		.strap(strap));
	ioh_err_decode_ctrl uut (
		.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
		.AVS_BYTEENABLE(4'hF), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
		.ERR_EV(ev), .ERR_REP(rep), .NP_ISSUE(np_i), .NP_CPL(np_c), .RX_TLP_VALID(rxv), .RX_TLP_BYTES(rxb),
		.RX_OVERSIZE(rxo), .TX_REQ_VALID(txv), .TX_REQ_BYTES(txb), .TX_REQ_ALLOW(txa), .MAX_PAYLOAD_BYTES(mps),
		.TAG_8BIT_EN(tag8), .RELAXED_ORDER_ORIG(ro), .IB_VALID(ibv), .IB_ADDR(iba), .IB_IN_CSR_RANGE(ibc),
		.IB_ABORT(ib_ab), .IB_PRIV_CSR(ib_pr), .DECODE(dec), .STRAP_PINS(strap)
	);
	task automatic end_sim;
		if (err_count == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			$display("unexpected %s exp %h got %h", n, e, g);
			err_count++;
		end
	endtask
	// Request stands until the rising edge that samples waitrequest low
	task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d);
		@(posedge clk_sys);
		addr <= {i, 2'h0};
		rd <= !w;
		wr <= w;
		wdata <= d;
		do begin
			@(posedge clk_sys);
		end while (waitreq !== 1'h0);
		r = rdata;
		rd <= 1'h0;
		wr <= 1'h0;
	endtask
	task automatic rdc(input string n, input logic [7:0] i, input logic [31:0] e);
		bus(1'h0, i, 32'h0);
		chk(n, e, r);
	endtask
	task automatic pay(input logic [11:0] b, input logic [1:0] e);
		@(posedge clk_sys);
		rxv <= 1'h1;
		txv <= 1'h1;
		rxb <= b;
		txb <= b;
		@(posedge clk_sys);
		rxv <= 1'h0;
		txv <= 1'h0;
		@(negedge clk_sys);
		chk("payload check", {30'h0, e}, {30'h0, rxo, txa});
	endtask
	task automatic evx(input logic [8:0] v, input logic [6:0] e);
		lm.pulse(ioh_err_ev_t'(v));
		@(negedge clk_sys);
		chk("report", {25'h0, e}, {25'h0, rep});
	endtask
	task automatic ibx(input logic [63:0] a, input logic c, input logic [1:0] e);
		lm.ib(a, c);
		@(negedge clk_sys);
		chk("inbound", {30'h0, e}, {30'h0, ib_ab, ib_pr});
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			end_sim;
		end
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'h0;
		@(negedge clk_sys);
		chk("decode", 32'h84, {21'h0, dec});
		rdc("ctl", ctl, 32'h0);
		rdc("misc", msc, 32'h20);
		bus(1'h1, stp, 32'h0);
		rdc("strap", stp, 32'h1E);
		bus(1'h1, 8'h10, 32'hFFFF_FFFF);
		rdc("unmapped", 8'h10, 32'h0);
		bus(1'h1, ctl, 32'hFFFF_FFFF);
		rdc("ctl", ctl, 32'h1FF);
		chk("tag", 32'h1, {31'h0, tag8});
		chk("relaxed", 32'h0, {31'h0, ro});
		for (int i = 0; i < 8; i++) begin
			bus(1'h1, ctl, 32'(i) << 5);
			repeat (2) @(negedge clk_sys);
			chk("payload", (i == 1) ? 32'h100 : 32'h80, {20'h0, mps});
		end
		chk("tag", 32'h0, {31'h0, tag8});
		bus(1'h1, ctl, 32'h20);
		pay(12'h100, 2'h1);
		pay(12'h101, 2'h2);
		for (int j = 0; j < 2; j++) begin
			bus(1'h1, ctl, j ? 32'hF : 32'h0);
			for (int k = 0; k < 4; k++)
				evx(9'h1 << evb[k], 7'(j) << (3 + k));
			rdc("sts", sts, 32'hF);
			bus(1'h1, sts, 32'hF);
		end
		evx(9'h080, 7'h0);
		evx(9'h008, 7'h10);
		bus(1'h1, ctl, 32'h0);
		evx(9'h004, 7'h04);
		rdc("sts", sts, 32'h6);
		bus(1'h1, sts, 32'hF);
		lm.np(1'h1, 1'h0);
		lm.np(1'h1, 1'h0);
		lm.np(1'h0, 1'h1);
		rdc("pending", sts, 32'h20);
		lm.np(1'h0, 1'h1);
		rdc("pending", sts, 32'h0);
		bus(1'h1, msc, 32'hFFFF_FFFF);
		rdc("misc", msc, 32'h3D24);
		chk("decode", 32'h764, {21'h0, dec});
		ibx(64'h10, 1'h1, 2'h2);
		ibx(64'h10_0000_0000, 1'h0, 2'h2);
		ibx(64'hF_FFFF_FFFF, 1'h0, 2'h1);
		ibx(64'hFFFF_FFFF, 1'h0, 2'h0);
		for (int i = 0; i < 3; i++) begin
			bus(1'h1, msc, 32'(i) << 10);
			repeat (2) @(negedge clk_sys);
			chk("decode", i ? 32'h4 : 32'h84, {21'h0, dec});
		end
		ibx(64'h10, 1'h1, 2'h0);
		ibx(64'h8_0000_0000, 1'h0, 2'h0);
		bus(1'h1, msc, 32'hFFFF_FFFF);
		sys_rst <= 1'h1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'h0;
		rdc("misc", msc, 32'h20);
		end_sim;
	end
endmodule
`default_nettype wire

// >>> testbench/ioh_link_model.sv
// Link-side partner: error events, non-posted traffic, inbound requests, straps.
// Assumes its tasks are called from one bench process on clk.
`timescale 1ns/10ps
`default_nettype none
module ioh_link_model
	import ioh_pkg::*;
#(
	parameter logic [2:0] STRAP = 3'h6
) (
	input  wire logic   clk,
	output ioh_err_ev_t ev,
	output logic        np_i,
	output logic        np_c,
	output logic        ibv,
	output logic [63:0] iba,
	output logic        ibc,
	output logic [2:0]  strap
);
	assign strap = STRAP;
	initial begin
		ev = '0;
		np_i = 1'h0;
		np_c = 1'h0;
		ibv = 1'h0;
		iba = 64'h0;
		ibc = 1'h0;
	end
	task automatic pulse(input ioh_err_ev_t e);
		@(posedge clk);
		ev <= e;
		@(posedge clk);
		ev <= '0;
	endtask
	task automatic np(input logic i, input logic c);
		@(posedge clk);
		np_i <= i;
		np_c <= c;
		@(posedge clk);
		np_i <= 1'h0;
		np_c <= 1'h0;
	endtask
	// Released lines flip, so a stale request never looks live
	task automatic ib(input logic [63:0] a, input logic c);
		@(posedge clk);
		ibv <= 1'h1;
		iba <= a;
		ibc <= c;
		@(posedge clk);
		ibv <= 1'h0;
		iba <= ~a;
		ibc <= ~c;
	endtask
endmodule
`default_nettype wire
